// File: hdl/tiosr_debounce.sv
`timescale 1ns/10ps
module tiosr_debounce import tiosr_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] time_i,
  output logic level_o
);

  if (CNT_W < 1) begin : g_chk
    $error("tiosr_debounce: CNT_W must be at least 1");
  end

  typedef struct packed {
    logic [2:0] sync;
    logic [CNT_W-1:0] cnt;
    logic level;
  } tiosr_deb_t;

  tiosr_deb_t s;
  tiosr_deb_t next_s;

  // A change is accepted only after the synced level differs from the
  // output for time_i ticks; any bounce back restarts the wait
  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[1:0], pin_i};
    if ((s.sync[2] == s.sync[1]) && (s.sync[2] != s.level)) begin
      if (s.cnt >= time_i) begin
        next_s.level = s.sync[2];
        next_s.cnt = '0;
      end else if (tick_i) begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end else begin
      next_s.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.level;

endmodule // tiosr_debounce

// File: hdl/tiosr_pkg.sv
package tiosr_pkg;

  // Clock and the time base shared by all filters
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = $clog2(TICK_CYCLES);

  // Terminal counts and field positions
  localparam int NUM_DIN = 6;
  localparam int AIN_BIT = 11;
  localparam int STO_CH_A = 4;
  localparam int STO_CH_B = 5;
  localparam int SRC_BIT_W = 4;

  // Source word numbers, placed above the 4-bit bit index
  localparam logic [11:0] WORD_INPUT = 12'h2D2;
  localparam logic [11:0] WORD_STATUS = 12'h034;
  localparam logic [11:0] WORD_STATUS_2 = 12'h035;

  // Configuration value that turns terminals 4 and 5 into the safety input
  localparam logic [7:0] MACRO_SAFETY = 8'h02;

  // Register indices on the plain register port
  localparam logic [7:0] REG_INPUT_STATE = 8'h00;
  localparam logic [7:0] REG_STATUS_WORD = 8'h01;
  localparam logic [7:0] REG_STATUS_WORD_2 = 8'h02;
  localparam logic [7:0] REG_MACRO_SELECT = 8'h03;
  localparam logic [7:0] REG_DEBOUNCE_TIME = 8'h04;
  localparam logic [7:0] REG_STO_FILTER_TIME = 8'h05;
  localparam logic [7:0] REG_OUT_INVERT = 8'h06;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h07;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_STO_STATE = 8'h09;
  localparam logic [7:0] REG_OUT_SRC_BASE = 8'h10;
  localparam logic [7:0] REG_FUNC_SRC_BASE = 8'h20;

  // Sticky event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_INPUT_CHANGE = 0;
  localparam int IRQ_STO_CHANGE = 1;
  localparam int IRQ_STO_FAULT = 2;

  // SAFE_TORQUE_OFF state register fields
  localparam int STO_SELECTED_BIT = 0;
  localparam int STO_FAULT_BIT = 1;

  // Reset values
  localparam logic [7:0] RST_MACRO = 8'h00;
  localparam logic [15:0] RST_DEBOUNCE = 16'h0004;
  localparam logic [15:0] RST_STO_FILTER = 16'h0005;
  localparam logic [15:0] RST_SOURCE = 16'h0000;

  // Control-function inputs that take a selectable source
  typedef enum int {
    FN_RAMP_STOP, FN_COAST_STOP, FN_QUICK_STOP, FN_ENABLE_OPERATION,
    FN_BRAKE_RELEASE, FN_BRAKE_CLOSE, FN_FIXED_SPEED0, FN_FIXED_SPEED1,
    FN_FIXED_SPEED2, FN_FIXED_SPEED3, FN_JOG0, FN_JOG1, FN_SETPOINT_INVERT,
    FN_FAULT_ACK, FN_EXT_FAULT, FN_EXT_ALARM, FN_WIRE_CMD1, FN_WIRE_CMD2,
    FN_WIRE_CMD3, FN_COUNT
  } tiosr_func_t;
  localparam int NUM_FUNC = FN_COUNT;

endpackage

// File: hdl/tiosr_router.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module tiosr_router import tiosr_pkg::*; #(
  parameter int NUM_DOUT = 2,
  parameter int TIME_W = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_DIN-1:0] din_i,
  input wire logic ain_digital_i,
  input wire logic [15:0] drive_status_word_i,
  input wire logic [15:0] drive_status_word_2_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [NUM_FUNC-1:0] func_o,
  output logic [NUM_DOUT-1:0] dout_o,
  output logic sto_selected_o,
  output logic sto_fault_o,
  output logic irq_o
);

  if (NUM_DOUT < 1 || NUM_DOUT > 16 || TIME_W < 1 || TIME_W > 16) begin : g_chk
    $error("tiosr_router: NUM_DOUT must be 1..16 and TIME_W 1..16");
  end

  typedef struct packed {
    logic [15:0] in_word;
    logic [15:0] status;
    logic [15:0] status_2;
    logic [7:0] macro;
    logic [15:0] deb_time;
    logic [15:0] sto_time;
    logic [15:0] inv_mask;
    logic [NUM_DOUT-1:0][15:0] out_src;
    logic [NUM_FUNC-1:0][15:0] func_src;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
    logic [NUM_FUNC-1:0] func;
    logic [NUM_DOUT-1:0] dout;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [TIME_W-1:0] disc_cnt;
    logic sto_sel;
    logic sto_fault;
    logic ack_d;
  } tiosr_state_t;

  tiosr_state_t s;
  tiosr_state_t next_s;

  logic [NUM_DIN:0] deb_level;
  wire logic [NUM_DIN:0] pin_all = {ain_digital_i, din_i};
  logic sto_ch_a;
  logic sto_ch_b;

  // Picks one bit out of the three routable words; an unknown word or a
  // zero selection yields a constant low
  function automatic logic src_bit(input logic [15:0] src, input logic [15:0] w_in,
                                   input logic [15:0] w_st, input logic [15:0] w_st2);
    logic [11:0] word;
    logic [SRC_BIT_W-1:0] idx;
    word = src[15:SRC_BIT_W];
    idx = src[SRC_BIT_W-1:0];
    case (word)
      WORD_INPUT: src_bit = w_in[idx];
      WORD_STATUS: src_bit = w_st[idx];
      WORD_STATUS_2: src_bit = w_st2[idx];
      default: src_bit = 1'b0;
    endcase
  endfunction

  // Debounce for the six terminals plus the analog input in digital use
  for (genvar gi = 0; gi <= NUM_DIN; gi++) begin : g_deb
    tiosr_debounce #(
      .CNT_W(TIME_W)
    ) u_deb (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(pin_all[gi]),
      .tick_i(s.tick),
      .time_i(s.deb_time[TIME_W-1:0]),
      .level_o(deb_level[gi])
    );
  end

  // Safety channels get their own filter so test pulses can be sized
  // independently of the ordinary debounce time
  tiosr_debounce #(
    .CNT_W(TIME_W)
  ) u_sto_a (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(din_i[STO_CH_A]),
    .tick_i(s.tick),
    .time_i(s.sto_time[TIME_W-1:0]),
    .level_o(sto_ch_a)
  );

  tiosr_debounce #(
    .CNT_W(TIME_W)
  ) u_sto_b (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(din_i[STO_CH_B]),
    .tick_i(s.tick),
    .time_i(s.sto_time[TIME_W-1:0]),
    .level_o(sto_ch_b)
  );

  // Next-state logic for the whole router
  always_comb begin
    logic safety_mode;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] clear;
    logic ack_rise;
    logic [15:0] rd;
    safety_mode = 1'b0;
    events = '0;
    clear = '0;
    ack_rise = 1'b0;
    rd = 16'h0000;
    next_s = s;

    // Time base for all filters, one pulse per tick period
    if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 1'b1;
      next_s.tick = 1'b0;
    end

    // Input word: terminals in bits 0..5, analog input in bit 11
    next_s.in_word = 16'h0000;
    next_s.in_word[NUM_DIN-1:0] = deb_level[NUM_DIN-1:0];
    next_s.in_word[AIN_BIT] = deb_level[NUM_DIN];
    if (next_s.in_word != s.in_word) begin
      events[IRQ_INPUT_CHANGE] = 1'b1;
    end

    // Status words are produced by the drive logic on this clock
    next_s.status = drive_status_word_i;
    next_s.status_2 = drive_status_word_2_i;

    // Every control-function input follows its own source selection
    for (int f = 0; f < NUM_FUNC; f++) begin
      next_s.func[f] = src_bit(s.func_src[f], s.in_word, s.status, s.status_2);
    end

    // Outputs: zero source stays off even when inverted, so an unused
    // terminal never energises a relay
    for (int d = 0; d < NUM_DOUT; d++) begin
      if (s.out_src[d] == RST_SOURCE) begin
        next_s.dout[d] = 1'b0;
      end else begin
        next_s.dout[d] = src_bit(s.out_src[d], s.in_word, s.status, s.status_2)
                         ^ s.inv_mask[d];
      end
    end

    // Safety input, active only in the safety terminal configuration
    safety_mode = (s.macro == MACRO_SAFETY);
    ack_rise = s.func[FN_FAULT_ACK] & ~s.ack_d;
    next_s.ack_d = s.func[FN_FAULT_ACK];
    if (!safety_mode) begin
      next_s.disc_cnt = '0;
      next_s.sto_fault = 1'b0;
    end else if (sto_ch_a != sto_ch_b) begin
      // Skew and test pulses are tolerated up to the filter time
      if (s.disc_cnt > s.sto_time[TIME_W-1:0]) begin
        next_s.sto_fault = 1'b1;
      end else if (s.tick) begin
        next_s.disc_cnt = s.disc_cnt + 1'b1;
      end
    end else begin
      next_s.disc_cnt = '0;
      if (ack_rise) begin
        next_s.sto_fault = 1'b0; // In safety mode cleared only once the channels agree
      end
    end
    if (next_s.sto_fault && !s.sto_fault) begin
      events[IRQ_STO_FAULT] = 1'b1;
    end

    // Mismatched channels keep the last agreed state; a fault forces
    // the safe side
    if (!safety_mode) begin
      next_s.sto_sel = 1'b0;
    end else if (next_s.sto_fault) begin
      next_s.sto_sel = 1'b1;
    end else if (sto_ch_a && sto_ch_b) begin
      next_s.sto_sel = 1'b0;
    end else if (!sto_ch_a && !sto_ch_b) begin
      next_s.sto_sel = 1'b1;
    end
    if (next_s.sto_sel != s.sto_sel) begin
      events[IRQ_STO_CHANGE] = 1'b1;
    end

    // Register writes; the three state words ignore writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_MACRO_SELECT: next_s.macro = reg_wdata_i[7:0];
        REG_DEBOUNCE_TIME: next_s.deb_time = reg_wdata_i;
        REG_STO_FILTER_TIME: next_s.sto_time = reg_wdata_i;
        REG_OUT_INVERT: next_s.inv_mask = reg_wdata_i;
        REG_IRQ_STATUS: clear = reg_wdata_i[IRQ_W-1:0];
        REG_IRQ_MASK: next_s.irq_mask = reg_wdata_i[IRQ_W-1:0];
        default: begin
          for (int d = 0; d < NUM_DOUT; d++) begin
            if (reg_addr_i == REG_OUT_SRC_BASE + 8'(d)) begin
              next_s.out_src[d] = reg_wdata_i;
            end
          end
          for (int f = 0; f < NUM_FUNC; f++) begin
            if (reg_addr_i == REG_FUNC_SRC_BASE + 8'(f)) begin
              next_s.func_src[f] = reg_wdata_i;
            end
          end
        end
      endcase
    end

    // Sticky events: a new event wins over a same-cycle clear
    next_s.irq_stat = (s.irq_stat & ~clear) | events;

    // Read data stands for exactly the cycle after the strobe
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_INPUT_STATE: rd = s.in_word;
        REG_STATUS_WORD: rd = s.status;
        REG_STATUS_WORD_2: rd = s.status_2;
        REG_MACRO_SELECT: rd = {8'h00, s.macro};
        REG_DEBOUNCE_TIME: rd = s.deb_time;
        REG_STO_FILTER_TIME: rd = s.sto_time;
        REG_OUT_INVERT: rd = s.inv_mask;
        REG_IRQ_STATUS: rd = {{(16 - IRQ_W){1'b0}}, s.irq_stat};
        REG_IRQ_MASK: rd = {{(16 - IRQ_W){1'b0}}, s.irq_mask};
        REG_STO_STATE: begin
          rd[STO_SELECTED_BIT] = s.sto_sel;
          rd[STO_FAULT_BIT] = s.sto_fault;
        end
        default: begin
          for (int d = 0; d < NUM_DOUT; d++) begin
            if (reg_addr_i == REG_OUT_SRC_BASE + 8'(d)) begin
              rd = s.out_src[d];
            end
          end
          for (int f = 0; f < NUM_FUNC; f++) begin
            if (reg_addr_i == REG_FUNC_SRC_BASE + 8'(f)) begin
              rd = s.func_src[f];
            end
          end
        end
      endcase
    end
    next_s.rdata = rd;
  end

  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.macro <= RST_MACRO;
      s.deb_time <= RST_DEBOUNCE;
      s.sto_time <= RST_STO_FILTER;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign reg_rdata_o = s.rdata;
  assign func_o = s.func;
  assign dout_o = s.dout;
  assign sto_selected_o = s.sto_sel;
  assign sto_fault_o = s.sto_fault;
  assign irq_o = |(s.irq_stat & s.irq_mask);

endmodule // tiosr_router

// File: test/tiosr_field_model.sv
`timescale 1ns/10ps
module tiosr_field_model (
  input wire logic core_clk_i,
  input wire logic [3:0] level_i,
  input wire logic safe_i,
  input wire logic dark_i,
  input wire logic break_i,
  output logic [5:0] din_o
);
  logic [5:0] pins = 6'h00;
  logic ch;
  assign din_o = pins;
  // One contact feeds both safety channels; a dark test drops both together
  assign ch = safe_i && !dark_i;
  // Channel B reads inverted only while the bench commands a broken cable
  always @(posedge core_clk_i) pins <= {ch ^ break_i, ch, level_i};
endmodule // tiosr_field_model

// File: test/tiosr_router_props.sv
`timescale 1ns/10ps
module tiosr_router_props import tiosr_pkg::*; #(
  parameter int NUM_DOUT = 2
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] drive_status_word_i,
  input wire logic [15:0] drive_status_word_2_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [NUM_DOUT-1:0] dout_o,
  input wire logic sto_selected_o,
  input wire logic sto_fault_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] src0, src1;
  logic [7:0] macro;
  logic [2:0] mask;
  logic [1:0] inv;
  // Shadow of the settings that steer outputs, safety and interrupt
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {src0, src1, macro, mask, inv} <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_OUT_SRC_BASE) src0 <= reg_wdata_i;
      if (reg_addr_i == REG_OUT_SRC_BASE + 8'h01) src1 <= reg_wdata_i;
      if (reg_addr_i == REG_MACRO_SELECT) macro <= reg_wdata_i[7:0];
      if (reg_addr_i == REG_IRQ_MASK) mask <= reg_wdata_i[2:0];
      if (reg_addr_i == REG_OUT_INVERT) inv <= reg_wdata_i[1:0];
    end
  end
  // Input-word sources are not judged here, the checker cannot see the filters
  function automatic logic lv(input logic [15:0] s, input logic i, input logic [15:0] w,
    input logic [15:0] w2);
    if (s[15:4] == WORD_STATUS) return w[s[3:0]] ^ i;
    if (s[15:4] == WORD_STATUS_2) return w2[s[3:0]] ^ i;
    return 1'b0;
  endfunction
  property p_dout0;
    $past(src0[15:4]) != WORD_INPUT |-> dout_o[0] == lv($past(src0), $past(inv[0]),
      $past(drive_status_word_i, 2), $past(drive_status_word_2_i, 2));
  endproperty
  a_dout0: assert property (p_dout0)
    else $error("output 0 off its source");
  property p_dout1;
    $past(src1[15:4]) != WORD_INPUT |-> dout_o[1] == lv($past(src1), $past(inv[1]),
      $past(drive_status_word_i, 2), $past(drive_status_word_2_i, 2));
  endproperty
  a_dout1: assert property (p_dout1)
    else $error("output 1 off its source");
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");
  property p_unmapped;
    $past(reg_rd_i && reg_addr_i == 8'hFF) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_sto_state;
    $past(reg_rd_i && reg_addr_i == REG_STO_STATE) |->
      reg_rdata_o[1:0] == {$past(sto_fault_o), $past(sto_selected_o)};
  endproperty
  a_sto_state: assert property (p_sto_state)
    else $error("safety state read mismatch");
  property p_fault_sel;
    sto_fault_o |-> sto_selected_o;
  endproperty
  a_fault_sel: assert property (p_fault_sel)
    else $error("fault without torque off");
  property p_macro_off;
    $past(macro) != MACRO_SAFETY && $past(macro, 2) != MACRO_SAFETY |->
      !sto_selected_o && !sto_fault_o;
  endproperty
  a_macro_off: assert property (p_macro_off)
    else $error("safety active outside safety macro");
  property p_irq_masked;
    mask == 3'h0 |-> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt while fully masked");
endmodule // tiosr_router_props

bind tiosr_router tiosr_router_props #(.NUM_DOUT(NUM_DOUT)) u_props (.core_clk_i, .reset_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .drive_status_word_i,
  .drive_status_word_2_i, .reg_rdata_o, .dout_o, .sto_selected_o, .sto_fault_o, .irq_o);

// File: test/tiosr_router_tb_top.sv
`timescale 1ns/10ps
module tiosr_router_tb_top import tiosr_pkg::*; ;
  localparam int SETTLE = 250;
  logic core_clk_i, reset_n_i, ain_digital_i, reg_wr_i, reg_rd_i, irq_o;
  logic sto_selected_o, sto_fault_o, sf, dark, brk;
  logic rd_seen = 1'b0;
  logic [5:0] din_i;
  logic [7:0] reg_addr_i;
  logic [15:0] drive_status_word_i, drive_status_word_2_i, reg_wdata_i, reg_rdata_o;
  logic [15:0] lfsr, in_word;
  logic [NUM_FUNC-1:0] func_o;
  logic [1:0] dout_o;
  logic [3:0] lvl, k;
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] ra[5] = '{REG_MACRO_SELECT, REG_DEBOUNCE_TIME, REG_STO_FILTER_TIME,
    REG_FUNC_SRC_BASE, 8'hFF};
  logic [15:0] rv[5] = '{16'h0000, RST_DEBOUNCE, RST_STO_FILTER, RST_SOURCE, 16'h0000};

  tiosr_router #(.NUM_DOUT(2), .TIME_W(16)) DUT (.core_clk_i, .reset_n_i, .din_i,
    .ain_digital_i, .drive_status_word_i, .drive_status_word_2_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .func_o, .dout_o, .sto_selected_o, .sto_fault_o,
    .irq_o);
  tiosr_field_model u_field (.core_clk_i, .level_i(lvl), .safe_i(sf), .dark_i(dark),
    .break_i(brk), .din_o(din_i));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR reg_rdata_o expected %h seen %h", e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // An idle cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    cyc(1);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (rd_seen && exp_q.size() > 0) cmp_word(exp_q.pop_front(), reg_rdata_o);
    rd_seen <= reg_rd_i;
  end
  task automatic chk_inputs();
    in_word = {4'h0, ain_digital_i, 5'h00, sf, sf, lvl};
    rd(REG_INPUT_STATE, in_word);
    for (int f = 0; f < NUM_FUNC; f++) begin
      cmp_bit("func_o", in_word[(f % 7 == 6) ? 11 : f % 7], func_o[f]);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {reset_n_i, ain_digital_i, reg_wr_i, reg_rd_i, sf, dark, brk, lvl} = '0;
    {drive_status_word_i, drive_status_word_2_i, reg_wdata_i, reg_addr_i} = '0;
    lfsr = 16'h003A;
    cyc(5);
    reset_n_i <= 1'b1;
    cyc(1);
    foreach (ra[i]) rd(ra[i], rv[i]);
    // Status words read back as driven, a write to the first one is dropped
    lfsr = step(lfsr);
    drive_status_word_i <= lfsr;
    drive_status_word_2_i <= ~lfsr;
    wr(REG_STATUS_WORD, 16'hFFFF);
    rd(REG_STATUS_WORD, lfsr);
    rd(REG_STATUS_WORD_2, ~lfsr);
    // Every bit of the status word and bits 0, 2 and 6 of status word 2 steered to output 1 over fresh words
    for (int b = 0; b < 19; b++) begin
      lfsr = step(lfsr);
      drive_status_word_i <= lfsr;
      drive_status_word_2_i <= ~lfsr;
      k = b < 16 ? 4'(b) : 4'((b - 16) * (b - 15));
      wr(REG_OUT_SRC_BASE + 8'h01, {b < 16 ? WORD_STATUS : WORD_STATUS_2, k});
      cyc(2);
      cmp_bit("dout_o[1]", b < 16 ? lfsr[k] : ~lfsr[k], dout_o[1]);
    end
    // Fault bit on output 0 plain, inverted, then a zero source stays off
    for (int v = 0; v < 4; v++) begin
      lfsr = step(lfsr);
      drive_status_word_i <= lfsr;
      wr(REG_OUT_INVERT, {15'h0000, v[1]});
      wr(REG_OUT_SRC_BASE, v < 3 ? 16'h0343 : 16'h0000);
      cyc(2);
      cmp_bit("dout_o[0]", v < 3 && (lfsr[3] ^ v[1]), dout_o[0]);
    end
    // Random terminal levels through the filter into the word and the functions
    wr(REG_DEBOUNCE_TIME, 16'h0003);
    for (int f = 0; f < NUM_FUNC; f++) begin
      wr(REG_FUNC_SRC_BASE + 8'(f), {WORD_INPUT, (f % 7 == 6) ? 4'hB : 4'(f % 7)});
    end
    repeat (4) begin
      lfsr = step(lfsr);
      {sf, ain_digital_i, lvl} <= lfsr[5:0];
      cyc(SETTLE);
      chk_inputs();
    end
    // A blip shorter than the filter never reaches the word
    lvl[0] <= ~lvl[0];
    cyc(30);
    rd(REG_INPUT_STATE, in_word);
    lvl[0] <= ~lvl[0];
    cyc(SETTLE);
    // Unmasked input change raises the interrupt, writing a one clears it
    wr(REG_IRQ_MASK, 16'h0001);
    wr(REG_IRQ_STATUS, 16'h0007);
    cmp_bit("irq_o", 1'b0, irq_o);
    lvl <= ~lvl;
    cyc(SETTLE);
    cmp_bit("irq_o", 1'b1, irq_o);
    rd(REG_IRQ_STATUS, 16'h0001);
    wr(REG_IRQ_STATUS, 16'h0001);
    cmp_bit("irq_o", 1'b0, irq_o);
    // Safety pair: agree high, agree low, dark test, brief then lasting split
    wr(REG_MACRO_SELECT, {8'h00, MACRO_SAFETY});
    wr(REG_STO_FILTER_TIME, 16'h0003);
    sf <= 1'b1;
    cyc(SETTLE);
    cmp_bit("sto_selected_o", 1'b0, sto_selected_o);
    sf <= 1'b0;
    cyc(SETTLE);
    cmp_bit("sto_selected_o", 1'b1, sto_selected_o);
    sf <= 1'b1;
    cyc(SETTLE);
    dark <= 1'b1;
    cyc(30);
    cmp_bit("sto_selected_o", 1'b0, sto_selected_o);
    dark <= 1'b0;
    brk <= 1'b1;
    cyc(30);
    brk <= 1'b0;
    cyc(SETTLE);
    cmp_bit("sto_fault_o", 1'b0, sto_fault_o);
    brk <= 1'b1;
    cyc(2 * SETTLE);
    cmp_bit("sto_fault_o", 1'b1, sto_fault_o);
    rd(REG_STO_STATE, 16'h0003);
    rd(REG_IRQ_STATUS, 16'h0007);
    // Fault holds once channels agree, until the acknowledge input rises
    brk <= 1'b0;
    lvl[0] <= 1'b0;
    cyc(SETTLE);
    wr(REG_FUNC_SRC_BASE + 8'(FN_FAULT_ACK), {WORD_INPUT, 4'h0});
    cmp_bit("sto_fault_o", 1'b1, sto_fault_o);
    lvl[0] <= 1'b1;
    cyc(SETTLE);
    cmp_bit("sto_fault_o", 1'b0, sto_fault_o);
    cmp_bit("sto_selected_o", 1'b0, sto_selected_o);
    wr(REG_MACRO_SELECT, 16'h0000);
    sf <= 1'b0;
    cyc(SETTLE);
    cmp_bit("sto_selected_o", 1'b0, sto_selected_o);
    give_verdict();
  end

  // Whole sequence needs some 4000 cycles; a hang is cut well past that
  initial begin
    cyc(20000);
    bad_count++;
    give_verdict();
  end
endmodule // tiosr_router_tb_top
